// file: core/serial_port_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from every design file that needs them
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define SP_CFG_OFF      8'h00
`define SP_STAT_OFF     8'h04
`define SP_MASK_OFF     8'h08
`define SP_RXDATA_OFF   8'h0C
`define SP_TXDATA_OFF   8'h10
`define SP_CTRL_OFF     8'h14
`define SP_LEVEL_OFF    8'h18
`define SP_CFG_BAUD_LSB 0
`define SP_CFG_PAR_LSB  3
`define SP_CFG_RESET    5'h05
`define SP_BAUD_MAX_SEL 3'h5
`define SP_ST_RXAV      0
`define SP_ST_RXERR     1
`define SP_ST_OVR       2
`define SP_ST_BRK       3
`define SP_ST_TXDONE    4
`define SP_ST_W         5
`define SP_CTL_QUERY    0
`define SP_CTL_FLUSH    1
`define SP_TX_LAST      8
`define SP_RX_VALID     31
`define SP_CLK_HZ       50000000
`define SP_BAUD_BASE    300
`define SP_OVERSAMPLE   16
`define SP_RX_DEPTH     128
`define SP_RX_HOLD      100
`define SP_RX_MARGIN    10
`define SP_TX_DEPTH     32
`define SP_CHAR_BRK     8'h03
`define SP_CHAR_NL      8'h0A
`endif

// file: core/serial_port_pkg.sv
// Types and the parity helper shared by the serial port files
// Assumes nothing beyond a SystemVerilog compiler
package serial_port_pkg;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} parity_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
  // Parity bit over seven data bits
  function automatic logic par_bit(input logic [6:0] d, input logic odd);
    return odd ? ~(^d) : (^d);
  endfunction
endpackage

// file: core/serial_tx.sv
// Character transmitter: one start bit, 8 bits, two stop bits
// Assumes a 16x bit-rate enable pulse and a start pulse only while idle
`timescale 1ns/1ps
module serial_tx
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick16,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       seven,
  input  wire logic       odd,
  output logic            txd_q,
  output logic            busy_q,
  output logic            done_q
);
  logic [10:0] sh_q;
  logic [3:0]  cnt_q;
  logic [3:0]  nbit_q;
  wire         b8 = seven ? serial_port_pkg::par_bit(data[6:0], odd) : data[7];
  wire         bit_end = busy_q & tick16 & (cnt_q == 4'hF);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q   <= 11'h7FF;
      cnt_q  <= 4'h0;
      nbit_q <= 4'h0;
      txd_q  <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        sh_q   <= {2'b11, b8, data[6:0], 1'b0};
        txd_q  <= 1'b0;
        cnt_q  <= 4'h0;
        nbit_q <= 4'h0;
        busy_q <= 1'b1;
      end
      else if (busy_q && tick16)
      begin
        cnt_q <= cnt_q + 4'h1;
        if (bit_end)
        begin
          if (nbit_q == 4'hA)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
          else
          begin
            sh_q   <= {1'b1, sh_q[10:1]};
            txd_q  <= sh_q[1];
            nbit_q <= nbit_q + 4'h1;
          end
        end
      end
    end
  end
endmodule

// file: core/serial_rx.sv
// Character receiver with parity and stop bit checks
// Assumes a synchronised line input and a 16x bit-rate enable pulse
`timescale 1ns/1ps
module serial_rx
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick16,
  input  wire logic       rxd,
  input  wire logic       seven,
  input  wire logic       odd,
  output logic            done_q,
  output logic [7:0]      data_q,
  output logic            err_q
);
  serial_port_pkg::rx_state_t state_q;
  logic [9:0] sh_q;
  logic [3:0] cnt_q;
  logic [3:0] nbit_q;
  wire  [9:0] w = {rxd, sh_q[9:1]};
  wire        perr = seven & (w[7] != serial_port_pkg::par_bit(w[6:0], odd));
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= serial_port_pkg::RX_IDLE;
      sh_q    <= 10'h000;
      cnt_q   <= 4'h0;
      nbit_q  <= 4'h0;
      done_q  <= 1'b0;
      data_q  <= 8'h00;
      err_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        serial_port_pkg::RX_IDLE:
          if (!rxd)
          begin
            state_q <= serial_port_pkg::RX_START;
            cnt_q   <= 4'h0;
          end
        serial_port_pkg::RX_START:
          if (tick16)
          begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7)
            begin
              cnt_q   <= 4'h0;
              nbit_q  <= 4'h0;
              state_q <= rxd ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_BITS;
            end
          end
        serial_port_pkg::RX_BITS:
          if (tick16)
          begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hF)
            begin
              sh_q   <= w;
              nbit_q <= nbit_q + 4'h1;
              if (nbit_q == 4'h9)
              begin
                done_q  <= 1'b1;
                data_q  <= seven ? {1'b0, w[6:0]} : w[7:0];
                err_q   <= perr | ~w[8] | ~w[9];
                state_q <= serial_port_pkg::RX_IDLE;
              end
            end
          end
        default: state_q <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end
endmodule

// file: core/serial_port_dtr_dsr_flow.sv
// Serial port with DTR/DSR flow control behind an AHB-Lite slave
// Assumes one 50 MHz clock, async active-low reset, word-wide accesses
// What this block does
// - Bit rate 300 to 9600 baud from configuration, 9600 after reset.
// - Formats: 8 bits no parity, or 7 bits even or odd parity.
// - Every frame has one start bit and two stop bits, fixed.
// - DTR is the hold-off output; characters taken while DTR true and up to RX_MARGIN more after it falls.
// - About 100 buffered characters drop DTR until space frees.
// - Query plus received newline hold DTR false until response sent.
// - DSR checked before each character; sending waits while it is false.
// - DTR stays false while sending is suspended by DSR.
// - Ctrl-C aborts work and discards pending output, like device clear.
// - Rate and parity survive an interface reset; only power-on resets them.
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module serial_port_dtr_dsr_flow
#(
  parameter int CLK_HZ    = `SP_CLK_HZ,
  parameter int RX_DEPTH  = `SP_RX_DEPTH,
  parameter int RX_HOLD   = `SP_RX_HOLD,
  parameter int RX_MARGIN = `SP_RX_MARGIN,
  parameter int TX_DEPTH  = `SP_TX_DEPTH
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd,
  input  wire logic        dsr,
  output logic             txd,
  output logic             dtr,
  output logic             irq
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);

  if ((1 << RAW) != RX_DEPTH || (1 << TAW) != TX_DEPTH || RAW > 7 || TAW > 7)
  begin : g_bad_depth
    $error("Buffer depths must be powers of two, 128 at most");
  end
  if (RX_DEPTH < RX_HOLD + RX_MARGIN || RX_HOLD < 1 || RX_MARGIN > 15)
  begin : g_bad_hold
    $error("Receive buffer too small for hold level plus margin");
  end
  if (CLK_HZ / (`SP_BAUD_BASE * `SP_OVERSAMPLE) > 65535 ||
      CLK_HZ / ((`SP_BAUD_BASE << 5) * `SP_OVERSAMPLE) < 2)
  begin : g_bad_clk
    $error("Clock rate out of range for the bit rate divider");
  end

  // Divider limit for a 16x tick at the selected rate
  function automatic logic [15:0] div_lim(input logic [2:0] sel);
    int d;
    d = CLK_HZ / ((`SP_BAUD_BASE << sel) * `SP_OVERSAMPLE);
    return 16'(d - 1);
  endfunction

  // Bus address phase and data phase
  logic        wr_q;
  logic [7:0]  waddr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  wire         ap    = hsel & hready & htrans[1];
  wire         ap_rd = ap & ~hwrite;
  wire  [7:0]  ra    = haddr[7:0];
  wire         wr_cfg  = wr_q & (waddr_q == `SP_CFG_OFF);
  wire         wr_stat = wr_q & (waddr_q == `SP_STAT_OFF);
  wire         wr_mask = wr_q & (waddr_q == `SP_MASK_OFF);
  wire         wr_tx   = wr_q & (waddr_q == `SP_TXDATA_OFF);
  wire         wr_ctl  = wr_q & (waddr_q == `SP_CTRL_OFF);
  wire         flush   = wr_ctl & hwdata[`SP_CTL_FLUSH];

  // Configuration, kept across flushes
  logic [4:0] cfg_q;
  wire  [2:0] baud_sel = cfg_q[`SP_CFG_BAUD_LSB +: 3];
  wire  [1:0] par_sel  = cfg_q[`SP_CFG_PAR_LSB +: 2];
  wire        seven    = (par_sel != serial_port_pkg::PAR_NONE);
  wire        odd      = (par_sel == serial_port_pkg::PAR_ODD);
  wire  [2:0] new_baud = hwdata[`SP_CFG_BAUD_LSB +: 3];
  wire  [1:0] new_par  = hwdata[`SP_CFG_PAR_LSB +: 2];
  wire        cfg_ok   = (new_baud <= `SP_BAUD_MAX_SEL) && (new_par != 2'h3);

  // Pin synchronisers, change taken when stages two and three agree
  logic [2:0] rxd_sq;
  logic [2:0] dsr_sq;
  logic       rxd_s;
  logic       dsr_s;

  // Bit rate divider
  logic [15:0] div_cnt_q;
  wire         tick16 = (div_cnt_q >= div_lim(baud_sel));

  // Receive path and buffer
  wire              rx_done;
  wire  [7:0]       rx_data;
  wire              rx_err;
  logic [8:0]       rx_mem [RX_DEPTH];
  logic [RAW-1:0]   rx_wp_q;
  logic [RAW-1:0]   rx_rp_q;
  logic [RAW:0]     rx_cnt_q;
  logic [3:0]       grace_q;
  wire              rx_brk   = rx_done & ~rx_err & (rx_data == `SP_CHAR_BRK);
  wire              rx_nl    = rx_done & (rx_data == `SP_CHAR_NL);
  wire              rx_room  = (rx_cnt_q != (RAW+1)'(RX_DEPTH));
  wire              rx_take  = dtr | (32'(grace_q) < RX_MARGIN);
  wire              rx_push  = rx_done & ~rx_brk & rx_take & rx_room & ~flush;
  wire              rx_drop  = rx_done & ~rx_brk & ~(rx_take & rx_room);
  wire              rx_pop   = ap_rd & (ra == `SP_RXDATA_OFF) & (rx_cnt_q != '0) & ~flush;
  wire              rx_hi    = (32'(rx_cnt_q) >= RX_HOLD);

  // Transmit buffer and launch
  logic [8:0]       tx_mem [TX_DEPTH];
  logic [TAW-1:0]   tx_wp_q;
  logic [TAW-1:0]   tx_rp_q;
  logic [TAW:0]     tx_cnt_q;
  logic             last_q;
  logic             tx_go_q;
  wire              tx_busy;
  wire              tx_done;
  wire              tx_full  = (tx_cnt_q == (TAW+1)'(TX_DEPTH));
  wire              tx_push  = wr_tx & ~tx_full & ~flush;
  wire              tx_pend  = (tx_cnt_q != '0);
  wire              tx_start = tx_pend & ~tx_busy & ~tx_go_q & dsr_s & ~flush;
  wire              tx_susp  = tx_pend & ~tx_busy & ~dsr_s;

  // Query hold-off and clears
  logic query_armed_q;
  logic nl_seen_q;
  wire  query_hold = query_armed_q & nl_seen_q;
  wire  resp_end   = tx_done & last_q;
  wire  abort      = flush | rx_brk;
  wire  dtr_d      = ~(rx_hi | query_hold | tx_susp);

  // Status and interrupt
  logic [`SP_ST_W-1:0] stat_q;
  logic [`SP_ST_W-1:0] mask_q;
  wire  [`SP_ST_W-1:0] stat_set = {resp_end, rx_brk, rx_drop, rx_push & rx_err, rx_push};
  wire  [`SP_ST_W-1:0] stat_clr = wr_stat ? hwdata[`SP_ST_W-1:0] : '0;

  // Read data selection
  wire [31:0] level_rd = {12'h000, query_hold, tx_busy, dsr_s, dtr,
                          8'(tx_cnt_q), 8'(rx_cnt_q)};
  wire [31:0] rxd_rd   = {(rx_cnt_q != '0), 22'h000000, rx_mem[rx_rp_q]};
  wire [31:0] rd_mux   = (ra == `SP_CFG_OFF)    ? {27'h0000000, cfg_q} :
                         (ra == `SP_STAT_OFF)   ? {27'h0000000, stat_q} :
                         (ra == `SP_MASK_OFF)   ? {27'h0000000, mask_q} :
                         (ra == `SP_RXDATA_OFF) ? rxd_rd :
                         (ra == `SP_LEVEL_OFF)  ? level_rd : 32'h00000000;

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q        <= 1'b0;
      waddr_q     <= 8'h00;
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      wr_q        <= ap & hwrite;
      if (ap)
        waddr_q <= ra;
      if (ap_rd)
        hrdata_q <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg_q <= `SP_CFG_RESET;
    else if (wr_cfg && cfg_ok)
      cfg_q <= {new_par, new_baud};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxd_sq <= 3'h7;
      dsr_sq <= 3'h0;
      rxd_s  <= 1'b1;
      dsr_s  <= 1'b0;
    end
    else
    begin
      rxd_sq <= {rxd_sq[1:0], rxd};
      dsr_sq <= {dsr_sq[1:0], dsr};
      if (rxd_sq[1] == rxd_sq[2])
        rxd_s <= rxd_sq[2];
      if (dsr_sq[1] == dsr_sq[2])
        dsr_s <= dsr_sq[2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_cnt_q <= 16'h0000;
    else
      div_cnt_q <= tick16 ? 16'h0000 : div_cnt_q + 16'h0001;
  end

  serial_rx u_rx
  (
    .clk    (hclk),
    .rst_n  (hresetn),
    .tick16 (tick16),
    .rxd    (rxd_s),
    .seven  (seven),
    .odd    (odd),
    .done_q (rx_done),
    .data_q (rx_data),
    .err_q  (rx_err)
  );

  serial_tx u_tx
  (
    .clk    (hclk),
    .rst_n  (hresetn),
    .tick16 (tick16),
    .start  (tx_go_q),
    .data   (tx_mem[tx_rp_q - TAW'(1)][7:0]),
    .seven  (seven),
    .odd    (odd),
    .txd_q  (txd),
    .busy_q (tx_busy),
    .done_q (tx_done)
  );

  always_ff @(posedge hclk)
  begin
    if (rx_push)
      rx_mem[rx_wp_q] <= {rx_err, rx_data};
    if (tx_push)
      tx_mem[tx_wp_q] <= hwdata[`SP_TX_LAST:0];
  end

  // Receive buffer pointers; a flush empties it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end
    else if (flush)
    begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end
    else
    begin
      rx_wp_q  <= rx_wp_q + RAW'(rx_push);
      rx_rp_q  <= rx_rp_q + RAW'(rx_pop);
      rx_cnt_q <= rx_cnt_q + (RAW+1)'(rx_push) - (RAW+1)'(rx_pop);
    end
  end

  // Characters let in after DTR fell, bounded by the margin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      grace_q <= 4'h0;
    else if (dtr)
      grace_q <= 4'h0;
    else if (rx_done && grace_q != 4'hF)
      grace_q <= grace_q + 4'h1;
  end

  // Transmit buffer; abort discards pending output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
      tx_go_q  <= 1'b0;
      last_q   <= 1'b0;
    end
    else if (abort)
    begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
      tx_go_q  <= 1'b0;
      last_q   <= 1'b0;
    end
    else
    begin
      tx_go_q  <= tx_start;
      tx_wp_q  <= tx_wp_q + TAW'(tx_push);
      tx_rp_q  <= tx_rp_q + TAW'(tx_start);
      tx_cnt_q <= tx_cnt_q + (TAW+1)'(tx_push) - (TAW+1)'(tx_start);
      if (tx_start)
        last_q <= tx_mem[tx_rp_q][`SP_TX_LAST];
    end
  end

  // Query hold: armed by software, completed by a received newline
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      query_armed_q <= 1'b0;
      nl_seen_q     <= 1'b0;
    end
    else if (abort || resp_end)
    begin
      query_armed_q <= 1'b0;
      nl_seen_q     <= 1'b0;
    end
    else
    begin
      if (wr_ctl && hwdata[`SP_CTL_QUERY])
        query_armed_q <= 1'b1;
      if (rx_nl && rx_push)
        nl_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dtr <= 1'b0;
    else
      dtr <= dtr_d;
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat_q <= '0;
      mask_q <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      if (wr_mask)
        mask_q <= hwdata[`SP_ST_W-1:0];
      irq <= |(stat_q & mask_q);
    end
  end
endmodule

// file: sim/serial_port_properties.sv
// Checker for the serial port: bus answers, reset levels and line framing
// Assumes hready is tied to hreadyout and a single clock domain
`timescale 1ns/1ps
module serial_port_checker
#(
  parameter int CLK_HZ = 50000000
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        txd,
  input wire logic        dtr,
  input wire logic        irq
);
  // Longest legal low run: start plus eight zero bits at the slowest rate
  localparam int LOW_MAX = 9 * 16 * (CLK_HZ / 4800) + 2;
  logic [31:0] low_q;
  logic [31:0] low_d;
  assign low_d = txd ? 32'h0 : low_q + 32'h1;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      low_q <= 32'h0;
    else
      low_q <= low_d;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence level_rd;
    rd_req ##0 (haddr[7:0] == 8'h18);
  endsequence
  sequence unmapped_rd;
    rd_req ##0 (haddr[7:0] >= 8'h1C);
  endsequence
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  zero_wait_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (unmapped_rd |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  dtr_mirror_a: assert property (level_rd |=> hrdata[16] == $past(dtr))
    else $error("status dtr differs from pin");
  dtr_after_reset_a: assert property (!$past(hresetn) |=> dtr)
    else $error("dtr not true after reset");
  quiet_after_reset_a: assert property (!$past(hresetn) |-> !irq ##1 !irq)
    else $error("interrupt right after reset");
  txd_idle_reset_a: assert property (!$past(hresetn) |-> txd [*2])
    else $error("line not idle after reset");
  low_bound_a: assert property (low_q <= LOW_MAX)
    else $error("line low longer than a frame allows");
endmodule
bind serial_port_dtr_dsr_flow serial_port_checker #(.CLK_HZ(CLK_HZ)) serial_port_checker_i
(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
 .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
 .hresp(hresp), .txd(txd), .dtr(dtr), .irq(irq));

// file: sim/host_model.sv
// Host end of the serial link: sends frames on rxd, collects frames from txd
// Assumes the testbench sets bitc to the bit time in cycles and may drive dsr
`timescale 1ns/1ps
module host_model
#(
  parameter int BIT = 160
)
(
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic dtr,
  output logic      rxd = 1'b1,
  output logic      dsr = 1'b1
);
  int         bitc = BIT;
  int         n_got = 0;
  logic [7:0] got;
  logic       stop_ok;
  // Start bit, eight bits LSB first, two stop bits
  task automatic send(input logic [7:0] p, input logic obey);
    logic [10:0] fr;
    fr = {2'b11, p, 1'b0};
    if (obey)
      wait (dtr === 1'b1);
    for (int i = 0; i < 11; i++)
    begin
      rxd <= fr[i];
      repeat (bitc) @(posedge clk);
    end
  endtask
  // Samples each incoming bit in its middle
  always
  begin
    wait (txd === 1'b0);
    repeat (bitc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bitc) @(posedge clk);
      got[i] = txd;
    end
    repeat (bitc) @(posedge clk);
    stop_ok = txd;
    repeat (bitc) @(posedge clk);
    stop_ok = stop_ok & txd;
    n_got++;
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench: bus tasks, host model on the line, directed tests
// Assumes the design, checker and host model are compiled first
`timescale 1ns/1ps
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic        hreadyout, hresp, rxd, dsr, txd, dtr, irq;
  int          err_total = 0;
  int          n_compared = 0;
  int          n0;
  logic [7:0]  cfg_t [5] = '{8'h05, 8'h0D, 8'h15, 8'h04, 8'h03};
  logic [7:0]  ch_t [5] = '{8'hA5, 8'h43, 8'h43, 8'h5A, 8'h96};
  logic [7:0]  pat_t [5] = '{8'hA5, 8'hC3, 8'h43, 8'h5A, 8'h96};
  int          bit_t [5] = '{160, 160, 160, 320, 640};
  always #10 hclk = ~hclk;
  serial_port_dtr_dsr_flow #(.CLK_HZ(1536000), .RX_HOLD(4)) serial_port_dtr_dsr_flow_i
  (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .dsr(dsr), .txd(txd), .dtr(dtr),
   .irq(irq));
  host_model #(.BIT(160)) host_model_i
  (.clk(hclk), .txd(txd), .dtr(dtr), .rxd(rxd), .dsr(dsr));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, rv & m);
  endtask
  task automatic summarize;
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge hclk);
    err_total++;
    summarize;
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("cfg reset", 8'h00, 32'h1F, 32'h05);
    rdchk("level dtr", 8'h18, 32'h10000, 32'h10000);
    rdchk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
    xfer(8'h00, 1'b1, 32'h06);
    rdchk("cfg refused", 8'h00, 32'h1F, 32'h05);
    for (int i = 0; i < 5; i++)
    begin
      xfer(8'h00, 1'b1, {24'h0, cfg_t[i]});
      host_model_i.bitc = bit_t[i];
      n0 = host_model_i.n_got;
      xfer(8'h10, 1'b1, {24'h0, ch_t[i]});
      wait (host_model_i.n_got != n0);
      chk("tx char", {24'h0, pat_t[i]}, {24'h0, host_model_i.got});
      chk("tx stops", 32'h1, {31'h0, host_model_i.stop_ok});
      host_model_i.send(pat_t[i], 1'b1);
      repeat (40) @(posedge hclk);
      rdchk("rx char", 8'h0C, 32'h800001FF, {24'h800000, ch_t[i]});
    end
    xfer(8'h00, 1'b1, 32'h0D);
    host_model_i.bitc = 160;
    xfer(8'h04, 1'b1, 32'h1F);
    xfer(8'h08, 1'b1, 32'h02);
    chk("irq masked", 32'h0, {31'h0, irq});
    host_model_i.send(8'h43, 1'b1);
    repeat (40) @(posedge hclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdchk("rx error", 8'h0C, 32'h800001FF, 32'h80000143);
    rdchk("stat error", 8'h04, 32'h02, 32'h02);
    xfer(8'h04, 1'b1, 32'h02);
    repeat (3) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdchk("mask", 8'h08, 32'h1F, 32'h02);
    for (int i = 0; i < 4; i++)
      host_model_i.send(8'h41, 1'b1);
    repeat (40) @(posedge hclk);
    chk("dtr full", 32'h0, {31'h0, dtr});
    xfer(8'h0C, 1'b0, 32'h0);
    repeat (4) @(posedge hclk);
    chk("dtr freed", 32'h1, {31'h0, dtr});
    xfer(8'h14, 1'b1, 32'h02);
    rdchk("flushed", 8'h18, 32'hFF, 32'h0);
    rdchk("rx empty", 8'h0C, 32'h80000000, 32'h0);
    rdchk("cfg kept", 8'h00, 32'h1F, 32'h0D);
    xfer(8'h14, 1'b1, 32'h01);
    host_model_i.send(8'h0A, 1'b1);
    repeat (40) @(posedge hclk);
    chk("dtr query", 32'h0, {31'h0, dtr});
    xfer(8'h04, 1'b1, 32'h1F);
    n0 = host_model_i.n_got;
    xfer(8'h10, 1'b1, 32'h14F);
    wait (host_model_i.n_got != n0);
    repeat (160) @(posedge hclk);
    chk("dtr answered", 32'h1, {31'h0, dtr});
    rdchk("stat sent", 8'h04, 32'h10, 32'h10);
    host_model_i.dsr <= 1'b0;
    repeat (10) @(posedge hclk);
    n0 = host_model_i.n_got;
    xfer(8'h10, 1'b1, 32'h41);
    repeat (320) @(posedge hclk);
    chk("dtr suspended", 32'h0, {31'h0, dtr});
    chk("tx held", n0, host_model_i.n_got);
    host_model_i.dsr <= 1'b1;
    wait (host_model_i.n_got != n0);
    chk("tx resumed", 32'h41, {24'h0, host_model_i.got});
    host_model_i.dsr <= 1'b0;
    repeat (200) @(posedge hclk);
    n0 = host_model_i.n_got;
    xfer(8'h10, 1'b1, 32'h42);
    repeat (20) @(posedge hclk);
    host_model_i.send(8'h03, 1'b0);
    repeat (40) @(posedge hclk);
    rdchk("stat abort", 8'h04, 32'h08, 32'h08);
    rdchk("tx discarded", 8'h18, 32'hFF00, 32'h0);
    host_model_i.dsr <= 1'b1;
    repeat (1920) @(posedge hclk);
    chk("no output", n0, host_model_i.n_got);
    summarize;
  end
endmodule
